/* lei_params.svh */
/*
  Constants for the extension instruction decoder: offsets, field
  positions, reset values, timing and frame rate table.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef LEI_PARAMS_SVH
`define LEI_PARAMS_SVH

// Timing
`define LEI_CLK_HZ      20000000
`define LEI_CLK_NS      50
`define LEI_EXEC_NS     200
`define LEI_BUSY_W      8
`define LEI_DIV_W       18
`define LEI_HZ_W        10
// Frame rates for trim codes 7 down to 0, in Hz
`define LEI_FRAME_HZ {10'h15B, 10'h115, 10'h0E3, 10'h0C0, \
                      10'h0A7, 10'h095, 10'h085, 10'h078}

// Register map
`define LEI_ADDR_W      4
`define LEI_OFS_INSTR   4'h0
`define LEI_OFS_STATUS  4'h4
`define LEI_OFS_POWER   4'h8
`define LEI_RESP_OK     2'h0
`define LEI_RESP_ERR    2'h2

// Instruction word fields
`define LEI_BIT_REGSEL  8
`define LEI_BIT_READ    9
`define LEI_FSET_TOP    3'h1
`define LEI_CGRAM_TOP   2'h1
`define LEI_NIB_BIAS    4'h1
`define LEI_NIB_ICON    4'h4
`define LEI_NIB_POWER   4'h5
`define LEI_NIB_FOLLOW  4'h6
`define LEI_NIB_CONTR   4'h7

// Reset values
`define LEI_RST_TRIM    3'h0
`define LEI_RST_GAIN    3'h0
`define LEI_RST_CONTR   6'h00
`define LEI_RST_ADDR    4'h0

`endif

/* lei_pkg.sv */
/*
  Types of the extension instruction decoder: the state records of
  the top module and of the frame tick divider.
  Assumes lei_params.svh on the include path.
*/
`include "lei_params.svh"

package lei_pkg;

  typedef logic [`LEI_BUSY_W-1:0] lei_busy_t;
  typedef logic [`LEI_DIV_W-1:0]  lei_div_t;
  typedef logic [`LEI_ADDR_W-1:0] lei_addr_t;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] pins;
    logic       aw_rdy;
    logic       w_rdy;
    logic       ar_rdy;
    logic       bvalid;
    logic       rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    lei_addr_t  waddr;
    logic [9:0] wdata;
    logic [1:0] wstrb;
    logic [31:0] rdata;
    lei_busy_t  busy_cnt;
    logic       busy;
    logic       ext_sel;
    logic       icon_sel;
    logic [3:0] ram_addr;
    logic [2:0] osc_trim_code;
    logic       bias_quarter;
    logic       icon_on;
    logic       boost_on;
    logic       follow_on;
    logic [2:0] v0_gain_ratio;
    logic [5:0] contrast_level;
  } lei_state_s;

  typedef struct packed {
    lei_div_t cnt;
    logic     tick;
  } lei_div_s;

endpackage

/* lei_frame_tick.sv */
/*
  Frame rate divider: one-cycle tick at the rate picked by the trim
  code. Assumes a synchronised reset and a trim code on this clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lei_params.svh"

module lei_frame_tick #(
  parameter int unsigned CLK_HZ = `LEI_CLK_HZ
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Rate select and tick
  input  wire logic [2:0] i_trim,
  output logic            o_tick
);

  localparam logic [8*`LEI_HZ_W-1:0] HZ_TAB = `LEI_FRAME_HZ;

  lei_pkg::lei_div_t per_m1 [8];
  lei_pkg::lei_div_t sel_m1;
  lei_pkg::lei_div_s st;
  lei_pkg::lei_div_s nx;

  // Period table, one reload value per trim code
  for (genvar g = 0; g < 8; g++) begin : g_per
    localparam int unsigned HZ = int'(HZ_TAB[g*`LEI_HZ_W +: `LEI_HZ_W]);
    assign per_m1[g] = lei_pkg::lei_div_t'(CLK_HZ / HZ - 1);
  end

  assign sel_m1 = per_m1[i_trim];

  // New trim takes effect at the next reload, so no frame is cut short
  always_comb begin
    nx = st;
    nx.tick = 1'b0;
    if (st.cnt == '0) begin
      nx.cnt  = sel_m1;
      nx.tick = 1'b1;
    end else begin
      nx.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign o_tick = st.tick;

  AST_TICK_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.cnt == '0) |=> st.tick && st.cnt == $past(sel_m1))
    else $error("frame divider reload wrong");

  COV_TICK: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st.tick);

endmodule
`default_nettype wire

/* lei_ext_decoder.sv */
/*
  Extension instruction decoder of a character display controller,
  with its instruction port reached over AXI4-Lite.
  Assumes one 20 MHz clock, option pins from outside the clock domain
  and a master that keeps one write and one read under way at most.
*/
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
// Functional notes
// - Trim code is stored only while the clock source option pin is high.
// - Trim codes pick eight ascending frame rates, 120 Hz up to 347 Hz.
// - Command 0100 loads low nibble into the address counter, selects icon RAM.
// - Icon address command works only in the extension table; range 0 to F.
// - Icon enable bit written high shows icons, written low blanks them.
// - Booster bit written only when both bias option pins are low.
// - Follower command 0110 carries enable in bit 3, gain in bits 2 to 0.
// - Follower enable written only when both bias option pins are low.
// - Gain ratio written only when both bias option pins are low.
// - Six-bit contrast split over two commands, written only with pins low.
// - Function set bit 0 selects extension table high, normal table low.
// - Busy stays high while executing; the host waits for it to fall.
`timescale 1ns/1ps
`default_nettype none
`include "lei_params.svh"

module lei_ext_decoder #(
  parameter int unsigned CLK_HZ   = `LEI_CLK_HZ,
  parameter int unsigned EXEC_CYC =
    (`LEI_EXEC_NS + `LEI_CLK_NS - 1) / `LEI_CLK_NS
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  // Option pins
  input  wire logic        I_CLOCK_SOURCE_OPTION_PIN,
  input  wire logic        I_BIAS_OPTION_PIN_ONE,
  input  wire logic        I_BIAS_OPTION_PIN_TWO,
  // AXI4-Lite write
  input  wire logic [3:0]  I_AXI_AWADDR,
  input  wire logic        I_AXI_AWVALID,
  output logic             O_AXI_AWREADY,
  input  wire logic [31:0] I_AXI_WDATA,
  input  wire logic [3:0]  I_AXI_WSTRB,
  input  wire logic        I_AXI_WVALID,
  output logic             O_AXI_WREADY,
  output logic [1:0]       O_AXI_BRESP,
  output logic             O_AXI_BVALID,
  input  wire logic        I_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [3:0]  I_AXI_ARADDR,
  input  wire logic        I_AXI_ARVALID,
  output logic             O_AXI_ARREADY,
  output logic [31:0]      O_AXI_RDATA,
  output logic [1:0]       O_AXI_RRESP,
  output logic             O_AXI_RVALID,
  input  wire logic        I_AXI_RREADY,
  // Display control
  output logic [2:0]       O_OSC_TRIM_CODE,
  output logic             O_BIAS_QUARTER,
  output logic             O_ICON_ON,
  output logic             O_BOOST_ON,
  output logic             O_FOLLOW_ON,
  output logic [2:0]       O_V0_GAIN_RATIO,
  output logic [5:0]       O_CONTRAST_LEVEL,
  output logic             O_FRAME_TICK,
  // Instruction state
  output logic             O_EXTENSION_TABLE_SELECT,
  output logic             O_ICON_RAM_SELECT,
  output logic [3:0]       O_RAM_ADDRESS_COUNTER,
  output logic             O_INTERNAL_BUSY_INDICATOR
);

  localparam lei_pkg::lei_busy_t EXEC_LD =
    lei_pkg::lei_busy_t'(EXEC_CYC);

  logic [1:0]          rst_q;
  logic                rst_n;
  lei_pkg::lei_state_s st;
  lei_pkg::lei_state_s nx;
  logic                clk_src_hi;
  logic                bias_int;
  logic                wr_go;
  logic                instr_hit;
  logic                do_issue;
  logic                regsel;
  logic                rd;
  logic                cmd_go;
  logic                ext_go;
  logic [7:0]          ib;
  logic [3:0]          nib;
  logic [3:0]          ib_lo;
  logic [2:0]          ib_lo3;
  logic                ib_b3;
  logic [31:0]         rd_word;
  logic [1:0]          rd_resp;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Decoded views of the captured instruction
  assign clk_src_hi = st.pins[2];
  assign bias_int   = ~st.pins[1] & ~st.pins[0];
  assign ib         = st.wdata[7:0];
  assign nib        = ib[7:4];
  assign ib_lo      = ib[3:0];
  assign ib_lo3     = ib[2:0];
  assign ib_b3      = ib[3];
  assign regsel     = st.wdata[`LEI_BIT_REGSEL] & st.wstrb[1];
  assign rd         = st.wdata[`LEI_BIT_READ] & st.wstrb[1];
  assign wr_go      = ~st.aw_rdy & ~st.w_rdy & ~st.bvalid;
  assign instr_hit  = (st.waddr == `LEI_OFS_INSTR) & st.wstrb[0];
  assign do_issue   = wr_go & instr_hit & ~st.busy;
  assign cmd_go     = do_issue & ~rd & ~regsel;
  assign ext_go     = cmd_go & st.ext_sel;

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `LEI_RESP_OK;
    if (I_AXI_ARADDR == `LEI_OFS_INSTR) begin
      rd_word = {22'h00_0000, st.wdata};
    end else if (I_AXI_ARADDR == `LEI_OFS_STATUS) begin
      rd_word = {21'h00_0000, st.pins, st.ram_addr, 1'b0,
                 st.icon_sel, st.ext_sel, st.busy};
    end else if (I_AXI_ARADDR == `LEI_OFS_POWER) begin
      rd_word = {10'h000, st.contrast_level, 5'h00, st.v0_gain_ratio,
                 1'b0, st.follow_on, st.boost_on, st.icon_on,
                 st.bias_quarter, st.osc_trim_code};
    end else begin
      rd_resp = `LEI_RESP_ERR;
    end
  end

  always_comb begin
    nx = st;
    nx.meta = {I_CLOCK_SOURCE_OPTION_PIN, I_BIAS_OPTION_PIN_ONE,
               I_BIAS_OPTION_PIN_TWO};
    nx.pins = st.meta;

    // Address and data are taken independently, in either order
    if (st.aw_rdy && I_AXI_AWVALID) begin
      nx.waddr  = I_AXI_AWADDR;
      nx.aw_rdy = 1'b0;
    end
    if (st.w_rdy && I_AXI_WVALID) begin
      nx.wdata = I_AXI_WDATA[9:0];
      nx.wstrb = I_AXI_WSTRB[1:0];
      nx.w_rdy = 1'b0;
    end
    if (wr_go) begin
      nx.bvalid = 1'b1;
      nx.bresp  = do_issue ? `LEI_RESP_OK : `LEI_RESP_ERR;
    end
    if (st.bvalid && I_AXI_BREADY) begin
      nx.bvalid = 1'b0;
      nx.aw_rdy = 1'b1;
      nx.w_rdy  = 1'b1;
    end

    if (st.ar_rdy && I_AXI_ARVALID) begin
      nx.ar_rdy = 1'b0;
      nx.rvalid = 1'b1;
      nx.rdata  = rd_word;
      nx.rresp  = rd_resp;
    end
    if (st.rvalid && I_AXI_RREADY) begin
      nx.rvalid = 1'b0;
      nx.ar_rdy = 1'b1;
    end

    if (st.busy_cnt != '0) begin
      nx.busy_cnt = st.busy_cnt - 1'b1;
    end
    // Read transfers execute nothing and leave busy alone
    if (do_issue && !rd) begin
      nx.busy_cnt = EXEC_LD;
    end

    // Icon data writes step the counter within its 16 entries
    if (do_issue && !rd && regsel && st.icon_sel) begin
      nx.ram_addr = st.ram_addr + 4'h1;
    end

    if (cmd_go) begin
      if (ib[7]) begin
        nx.icon_sel = 1'b0;
      end else if (ib[7:5] == `LEI_FSET_TOP) begin
        nx.ext_sel = ib[0];
      end else if (!st.ext_sel && ib[7:6] == `LEI_CGRAM_TOP) begin
        nx.icon_sel = 1'b0;
      end
    end

    if (ext_go) begin
      case (nib)
        `LEI_NIB_BIAS: begin
          if (clk_src_hi) begin
            nx.osc_trim_code = ib_lo3;
          end
          if (st.pins[1:0] != 2'h3) begin
            nx.bias_quarter = ib_b3;
          end
        end
        `LEI_NIB_ICON: begin
          nx.ram_addr = ib_lo;
          nx.icon_sel = 1'b1;
        end
        `LEI_NIB_POWER: begin
          nx.icon_on = ib_b3;
          if (bias_int) begin
            nx.boost_on            = ib[2];
            nx.contrast_level[5:4] = ib[1:0];
          end
        end
        `LEI_NIB_FOLLOW: begin
          if (bias_int) begin
            nx.follow_on     = ib_b3;
            nx.v0_gain_ratio = ib_lo3;
          end
        end
        `LEI_NIB_CONTR: begin
          if (bias_int) begin
            nx.contrast_level[3:0] = ib_lo;
          end
        end
        default: begin
        end
      endcase
    end

    nx.busy = (nx.busy_cnt != '0);
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st                <= '0;
      st.aw_rdy         <= 1'b1;
      st.w_rdy          <= 1'b1;
      st.ar_rdy         <= 1'b1;
      st.ram_addr       <= `LEI_RST_ADDR;
      st.osc_trim_code  <= `LEI_RST_TRIM;
      st.v0_gain_ratio  <= `LEI_RST_GAIN;
      st.contrast_level <= `LEI_RST_CONTR;
    end else begin
      st <= nx;
    end
  end

  lei_frame_tick #(
    .CLK_HZ (CLK_HZ)
  ) u_tick (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .i_trim  (st.osc_trim_code),
    .o_tick  (O_FRAME_TICK)
  );

  assign O_AXI_AWREADY             = st.aw_rdy;
  assign O_AXI_WREADY              = st.w_rdy;
  assign O_AXI_BRESP               = st.bresp;
  assign O_AXI_BVALID              = st.bvalid;
  assign O_AXI_ARREADY             = st.ar_rdy;
  assign O_AXI_RDATA               = st.rdata;
  assign O_AXI_RRESP               = st.rresp;
  assign O_AXI_RVALID              = st.rvalid;
  assign O_OSC_TRIM_CODE           = st.osc_trim_code;
  assign O_BIAS_QUARTER            = st.bias_quarter;
  assign O_ICON_ON                 = st.icon_on;
  assign O_BOOST_ON                = st.boost_on;
  assign O_FOLLOW_ON               = st.follow_on;
  assign O_V0_GAIN_RATIO           = st.v0_gain_ratio;
  assign O_CONTRAST_LEVEL          = st.contrast_level;
  assign O_EXTENSION_TABLE_SELECT  = st.ext_sel;
  assign O_ICON_RAM_SELECT         = st.icon_sel;
  assign O_RAM_ADDRESS_COUNTER     = st.ram_addr;
  assign O_INTERNAL_BUSY_INDICATOR = st.busy;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!rst_n);

  AST_TRIM_LOAD: assert property (
    ext_go && nib == `LEI_NIB_BIAS && clk_src_hi
    |=> st.osc_trim_code == $past(ib_lo3))
    else $error("trim code not loaded");

  AST_TRIM_HOLD: assert property (
    ext_go && nib == `LEI_NIB_BIAS && !clk_src_hi
    |=> $stable(st.osc_trim_code))
    else $error("trim changed with clock source low");

  AST_ICON_ADDR: assert property (
    ext_go && nib == `LEI_NIB_ICON
    |=> st.icon_sel && st.ram_addr == $past(ib_lo))
    else $error("icon address not loaded");

  AST_ICON_NORMAL: assert property (
    cmd_go && !st.ext_sel && nib == `LEI_NIB_ICON
    |=> !st.icon_sel && $stable(st.ram_addr))
    else $error("icon address taken in normal table");

  AST_ICON_ON: assert property (
    ext_go && nib == `LEI_NIB_POWER
    |=> st.icon_on == $past(ib_b3))
    else $error("icon enable not written");

  AST_FOLLOW: assert property (
    ext_go && bias_int && nib == `LEI_NIB_FOLLOW
    |=> st.follow_on == $past(ib_b3)
        && st.v0_gain_ratio == $past(ib_lo3))
    else $error("follower command not applied");

  AST_CONTRAST: assert property (
    ext_go && bias_int && nib == `LEI_NIB_CONTR
    |=> st.contrast_level[3:0] == $past(ib_lo)
        && $stable(st.contrast_level[5:4]))
    else $error("contrast low nibble wrong");

  AST_LOCKED: assert property (
    ext_go && !bias_int && nib inside {[4'h5:4'h7]}
    |=> $stable(st.boost_on) && $stable(st.follow_on)
        && $stable(st.v0_gain_ratio) && $stable(st.contrast_level))
    else $error("locked field changed under external bias");

  AST_EXT_SEL: assert property (
    cmd_go && ib[7:5] == `LEI_FSET_TOP
    |=> st.ext_sel == $past(ib[0]))
    else $error("table select not updated");

  AST_BUSY_SPAN: assert property (
    do_issue && !rd |=> st.busy [*4] ##1 !st.busy)
    else $error("busy span wrong");

  AST_BUSY_REFUSE: assert property (
    wr_go && instr_hit && st.busy
    |=> st.bvalid && st.bresp == `LEI_RESP_ERR)
    else $error("instruction taken while busy");

  AST_B_HOLD: assert property (
    st.bvalid && !I_AXI_BREADY |=> st.bvalid && $stable(st.bresp))
    else $error("write response dropped");

  COV_ICON_ADDR: cover property (ext_go && nib == `LEI_NIB_ICON);
  COV_CONTRAST: cover property (
    ext_go && bias_int && nib == `LEI_NIB_CONTR);
  COV_REFUSE: cover property (wr_go && instr_hit && st.busy);
  COV_EXT_ON: cover property (cmd_go && ib == 8'h21);

endmodule
`default_nettype wire

/* lei_ext_decoder_dummy_end.sv */
`timescale 1ns/1ps

/* lei_host_model.sv */
/*
  Host model: AXI4-Lite master that issues instruction words.
  Assumes its tasks are called right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module lei_host_model (
  // Clock
  input  wire logic        i_clk,
  // Write channels
  output logic [3:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  // Read channels
  output logic [3:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end

  // Readies sampled at the falling edge: they only move on rising edges
  task automatic write(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    logic pa, pw, ta, tw, tb, done;
    logic [1:0] rs;
    int n;
    {pa, pw, done} = 3'b110;
    n = 0;
    r = 2'h3;
    @(posedge i_clk);
    o_awaddr  <= a;
    o_wdata   <= d;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    while (!done && n < 500) begin
      @(negedge i_clk);
      ta = pa && i_awready;
      tw = pw && i_wready;
      tb = i_bvalid;
      rs = i_bresp;
      @(posedge i_clk);
      if (ta) begin
        o_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        o_wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (tb) begin
        o_bready <= 1'b0;
        r = rs;
        done = 1'b1;
      end
      n++;
    end
  endtask

  task automatic read(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    logic pa, ta, tr, done;
    int n;
    {pa, done} = 2'b10;
    n = 0;
    r = 2'h3;
    d = '0;
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    while (!done && n < 500) begin
      @(negedge i_clk);
      ta = pa && i_arready;
      tr = i_rvalid;
      if (tr) begin
        d = i_rdata;
        r = i_rresp;
      end
      @(posedge i_clk);
      if (ta) begin
        o_arvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tr) begin
        o_rready <= 1'b0;
        done = 1'b1;
      end
      n++;
    end
  endtask

  // Instruction, then poll busy before anything else goes out
  task automatic instr(input logic [9:0] w, output logic [1:0] r);
    logic [31:0] s;
    logic [1:0]  q;
    int n;
    n = 0;
    s = 32'h1;
    write(4'h0, {22'h0, w}, r);
    while (s[0] && n < 50) begin
      read(4'h4, s, q);
      n++;
    end
  endtask
endmodule

`default_nettype wire

/* lei_ext_decoder_bench.sv */
/*
  Self-checking bench of the extension instruction decoder.
  Assumes lei_host_model as the AXI4-Lite master, CLK_HZ cut to 12000.
*/
`timescale 1ns/1ps
`default_nettype none

module lei_ext_decoder_bench;
  logic        clk, nrst, cs_pin, p1, p2;
  logic [3:0]  awaddr, araddr, ac;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r, q;
  logic [2:0]  trim, gain, e_trim, e_gain;
  logic        bq, icon, boost, follow, tick, ext, isel, busy;
  logic        e_bias, e_icon, e_boost, e_follow;
  logic [5:0]  contr, e_contr;
  logic [7:0]  b;
  logic [3:0]  nib [4] = '{4'h1, 4'h5, 4'h6, 4'h7};
  int          rate [8] = '{120, 133, 149, 167, 192, 227, 277, 347};
  int          errors, checked, seed, i, g;

  lei_ext_decoder #(.CLK_HZ(12000)) u_lei_ext_decoder (
    .I_CLK(clk), .I_NRST(nrst), .I_CLOCK_SOURCE_OPTION_PIN(cs_pin),
    .I_BIAS_OPTION_PIN_ONE(p1), .I_BIAS_OPTION_PIN_TWO(p2),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
    .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
    .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .O_OSC_TRIM_CODE(trim), .O_BIAS_QUARTER(bq),
    .O_ICON_ON(icon), .O_BOOST_ON(boost), .O_FOLLOW_ON(follow),
    .O_V0_GAIN_RATIO(gain), .O_CONTRAST_LEVEL(contr),
    .O_FRAME_TICK(tick), .O_EXTENSION_TABLE_SELECT(ext),
    .O_ICON_RAM_SELECT(isel), .O_RAM_ADDRESS_COUNTER(ac),
    .O_INTERNAL_BUSY_INDICATOR(busy));

  lei_host_model u_lei_host_model (
    .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
    .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
    .i_rvalid(rvalid), .o_rready(rready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic st(input logic [3:0] a, input logic s, x);
    u_lei_host_model.read(4'h4, d, q);
    chk(d, {21'h0, cs_pin, p1, p2, a, 1'b0, s, x, 1'b0}, "status");
  endtask

  // Expected effect of an extension-table byte under the current pins
  task automatic apply(input logic [7:0] v);
    case (v[7:4])
      4'h1: begin
        if (!(p1 && p2)) e_bias = v[3];
        if (cs_pin) e_trim = v[2:0];
      end
      4'h5: begin
        e_icon = v[3];
        if (!p1 && !p2) {e_boost, e_contr[5:4]} = v[2:0];
      end
      4'h6: if (!p1 && !p2) {e_follow, e_gain} = v[3:0];
      4'h7: if (!p1 && !p2) e_contr[3:0] = v[3:0];
      default: ;
    endcase
  endtask

  // Cycles from one tick to the next, sampled off the clock edge
  task automatic gap(output int n);
    int k;
    k = 0;
    @(negedge clk);
    while (!tick && k < 2000) begin
      @(negedge clk);
      k++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!tick && n < 2000);
  endtask

  initial begin
    #4000000;
    errors++;
    conclude();
  end

  initial begin
    seed = 32'h154d;
    {errors, checked} = '0;
    {nrst, cs_pin, p1, p2} = 4'b0100;
    {e_trim, e_gain, e_bias, e_icon, e_boost, e_follow, e_contr} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    u_lei_host_model.instr(10'h021, r);
    st(4'h0, 1'b0, 1'b1);
    u_lei_host_model.instr(10'h04F, r);
    st(4'hF, 1'b1, 1'b1);
    u_lei_host_model.instr(10'h100, r);
    st(4'h0, 1'b1, 1'b1);
    $display("test address done");
    u_lei_host_model.write(4'h0, 32'h43, r);
    u_lei_host_model.write(4'h0, 32'h4A, r);
    chk(32'(r), 32'h2, "write while busy");
    u_lei_host_model.instr(10'h24C, r);
    st(4'h3, 1'b1, 1'b1);
    u_lei_host_model.write(4'hC, 32'h5F, r);
    u_lei_host_model.read(4'hC, d, q);
    chk({d[29:0], r}, {30'h0, 2'h2}, "unmapped write");
    chk({d[29:0], q}, {30'h0, 2'h2}, "unmapped read");
    $display("test busy done");
    for (i = 0; i < 24; i++) begin
      {cs_pin, p1, p2} <= 3'($random(seed));
      repeat (4) @(posedge clk);
      b = {nib[2'($random(seed))], 4'($random(seed))};
      u_lei_host_model.instr({2'b00, b}, r);
      apply(b);
      u_lei_host_model.read(4'h8, d, q);
      chk(d, {10'h0, e_contr, 5'h0, e_gain, 1'b0, e_follow, e_boost,
              e_icon, e_bias, e_trim}, "power");
      chk({16'h0, trim, bq, icon, boost, follow, gain, contr},
          {16'h0, e_trim, e_bias, e_icon, e_boost, e_follow, e_gain,
           e_contr}, "outputs");
    end
    $display("test fields done");
    {cs_pin, p1, p2} <= 3'b100;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      u_lei_host_model.instr({7'h02, i[2:0]}, r);
      gap(g);
      gap(g);
      chk(32'(g), 32'(12000 / rate[i]), "frame period");
    end
    $display("test frame done");
    u_lei_host_model.instr(10'h020, r);
    u_lei_host_model.instr(10'h045, r);
    st(4'h3, 1'b0, 1'b0);
    $display("test normal table done");
    conclude();
  end
endmodule

`default_nettype wire
